// ===== src/ssp_spi_top.sv
// Synchronous serial port in SPI mode behind an AXI4-Lite register slave
module ssp_spi_top #(
    parameter int ADDR_W = 12
) (
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    input  wire logic [ADDR_W-1:0]     s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    input  wire logic [ADDR_W-1:0]     s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    input  wire logic                  tmr2_tick,
    input  wire ssp_pkg::ssp_pin_in_t  pin_i,
    output ssp_pkg::ssp_pin_out_t      pin_o,
    output logic                       irq
);
    ssp_pkg::ssp_state_t q;
    ssp_pkg::ssp_state_t d;
    logic       en_w;
    logic       master_w;
    logic       ss_rst;
    logic       pol;
    logic       cke;
    logic [3:0] mode;
    logic       ev_done;
    logic       out_e;
    logic       smp_e;
    logic       rd_buf;

    // Address lies on a mapped register
    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        logic [7:0] i;
        i = a[ssp_pkg::IDX_LSB +: ssp_pkg::IDX_W];
        if ((a >> (ssp_pkg::IDX_LSB + ssp_pkg::IDX_W)) != '0) begin
            return 1'b0;
        end
        return (i == ssp_pkg::IDX_GCTL) || (i == ssp_pkg::IDX_PFLG) ||
               (i == ssp_pkg::IDX_BUF) || (i == ssp_pkg::IDX_CON) ||
               (i == ssp_pkg::IDX_DIRA) || (i == ssp_pkg::IDX_DIRC) ||
               (i == ssp_pkg::IDX_PEN) || (i == ssp_pkg::IDX_STAT);
    endfunction

    // Read value of a register
    function automatic logic [7:0] rd_val(input ssp_pkg::ssp_state_t s,
                                          input logic [7:0] i);
        case (i)
            ssp_pkg::IDX_GCTL:   return s.gctl;
            ssp_pkg::IDX_PFLG:   return s.pflg;
            ssp_pkg::IDX_PEN:    return s.pen;
            ssp_pkg::IDX_BUF:    return s.sbuf;
            ssp_pkg::IDX_CON:    return s.con;
            ssp_pkg::IDX_DIRA:   return s.dira;
            ssp_pkg::IDX_DIRC:   return s.dirc;
            ssp_pkg::IDX_STAT:   return {s.cfg, 5'h00, s.full};
            default:             return 8'h00;
        endcase
    endfunction

    // Half period of the master clock for a rate code
    function automatic logic [5:0] half_of(input logic [3:0] m);
        case (m)
            ssp_pkg::MD_M16: return ssp_pkg::HALF_16;
            ssp_pkg::MD_M64: return ssp_pkg::HALF_64;
            default:         return ssp_pkg::HALF_4;
        endcase
    endfunction

    // Decoded configuration
    assign en_w     = q.con[ssp_pkg::CON_EN];
    assign mode     = q.con[3:0];
    assign pol      = q.con[ssp_pkg::CON_POL];
    assign cke      = q.cfg[0];
    assign master_w = en_w && (mode <= ssp_pkg::MD_MT2);
    assign ss_rst   = en_w && (mode == ssp_pkg::MD_SSS) && q.ss_s;

    // Bus handshakes
    assign s_axi_awready = !q.aw_ok && !q.bvalid;
    assign s_axi_wready  = !q.w_ok && !q.bvalid;
    assign s_axi_bvalid  = q.bvalid;
    assign s_axi_bresp   = q.bresp;
    assign s_axi_arready = !q.rvalid;
    assign s_axi_rvalid  = q.rvalid;
    assign s_axi_rresp   = q.rresp;
    assign s_axi_rdata   = {24'h000000, q.rdata};

    // Pins and interrupt
    assign pin_o.sck_o  = q.sck;
    assign pin_o.sck_oe = master_w && !q.dirc[ssp_pkg::TRC_SCK];
    assign pin_o.sdo_o  = q.tx_sr[7];
    assign pin_o.sdo_oe = en_w && !q.dirc[ssp_pkg::TRC_SDO] && !ss_rst;
    assign irq          = |(q.pflg & q.pen & ssp_pkg::PIR_USED);

    // Next state of the whole port
    always_comb begin
        logic       wr_buf;
        logic       edge_e;
        logic       rising;
        logic       tick;
        logic [7:0] ridx;
        d       = q;
        wr_buf  = 1'b0;
        edge_e  = 1'b0;
        rising  = 1'b0;
        tick    = 1'b0;
        ev_done = 1'b0;
        out_e   = 1'b0;
        smp_e   = 1'b0;
        rd_buf  = 1'b0;
        ridx    = s_axi_araddr[ssp_pkg::IDX_LSB +: ssp_pkg::IDX_W];
        // Pin synchronisers
        d.sck_m = pin_i.sck;
        d.sck_s = q.sck_m;
        d.sck_p = q.sck_s;
        d.sdi_m = pin_i.serial_in_pin;
        d.sdi_s = q.sdi_m;
        d.ss_m  = pin_i.ss_n;
        d.ss_s  = q.ss_m;
        // Write address and data, taken in either order
        if (s_axi_awvalid && s_axi_awready) begin
            d.aw_ok  = 1'b1;
            d.aw_idx = s_axi_awaddr[ssp_pkg::IDX_LSB +: ssp_pkg::IDX_W];
            d.aw_bad = !is_mapped(s_axi_awaddr);
        end
        if (s_axi_wvalid && s_axi_wready) begin
            d.w_ok   = 1'b1;
            d.w_dat  = s_axi_wdata[7:0];
            d.w_lane = s_axi_wstrb[0];
        end
        if (q.bvalid && s_axi_bready) begin
            d.bvalid = 1'b0;
        end
        // Register write once both halves are in
        if (q.aw_ok && q.w_ok && !q.bvalid) begin
            d.aw_ok  = 1'b0;
            d.w_ok   = 1'b0;
            d.bvalid = 1'b1;
            d.bresp  = q.aw_bad ? ssp_pkg::RESP_ERR : ssp_pkg::RESP_OKAY;
            if (!q.aw_bad && q.w_lane) begin
                case (q.aw_idx)
                    ssp_pkg::IDX_GCTL:   d.gctl = q.w_dat;
                    ssp_pkg::IDX_PFLG:   d.pflg = q.pflg & ~q.w_dat;
                    ssp_pkg::IDX_PEN:    d.pen = q.w_dat & ssp_pkg::PIR_USED;
                    ssp_pkg::IDX_CON:    d.con = q.w_dat;
                    ssp_pkg::IDX_STAT:   d.cfg = q.w_dat[ssp_pkg::STAT_SPH:ssp_pkg::STAT_CKE];
                    ssp_pkg::IDX_DIRA:   d.dira = q.w_dat & ssp_pkg::DIRA_MASK;
                    ssp_pkg::IDX_DIRC:   d.dirc = q.w_dat;
                    ssp_pkg::IDX_BUF:    wr_buf = 1'b1;
                    default: ;
                endcase
            end
        end
        // Register read
        if (s_axi_arvalid && s_axi_arready) begin
            d.rvalid = 1'b1;
            if (is_mapped(s_axi_araddr)) begin
                d.rdata = rd_val(q, ridx);
                d.rresp = ssp_pkg::RESP_OKAY;
                rd_buf  = (ridx == ssp_pkg::IDX_BUF);
            end else begin
                d.rdata = 8'h00;
                d.rresp = ssp_pkg::RESP_ERR;
            end
        end
        if (q.rvalid && s_axi_rready) begin
            d.rvalid = 1'b0;
        end
        // Buffer write loads the shift register or collides
        if (wr_buf) begin
            if (q.busy || (q.nsamp != 4'h0)) begin
                d.con[ssp_pkg::CON_COL] = 1'b1;
            end else begin
                d.tx_sr = q.w_dat;
                d.busy  = master_w;
            end
        end
        // Disabled port or raised select holds the shifter in reset
        if (!en_w || ss_rst) begin
            d.nsamp = 4'h0;
            d.nedge = 5'h00;
            d.pend  = 1'b0;
            d.busy  = 1'b0;
            d.div   = 6'h00;
            d.sck   = pol;
        end else begin
            if (master_w) begin
                if (mode == ssp_pkg::MD_MT2) begin
                    tick = tmr2_tick;
                end else begin
                    tick = (q.div == (half_of(mode) - 6'h01));
                end
                if (!q.busy) begin
                    d.sck = pol;
                    d.div = 6'h00;
                end else begin
                    d.div = tick ? 6'h00 : q.div + 6'h01;
                    if (tick) begin
                        edge_e  = 1'b1;
                        rising  = !q.sck;
                        d.sck   = !q.sck;
                        d.nedge = q.nedge + 5'h01;
                        if (q.nedge == ssp_pkg::LAST_EDGE) begin
                            d.busy  = 1'b0;
                            d.nedge = 5'h00;
                        end
                    end
                end
            end else begin
                edge_e = q.sck_s ^ q.sck_p;
                rising = q.sck_s;
            end
            // Output changes on the chosen edge, input sampled on the other
            out_e = edge_e && (rising == cke);
            smp_e = edge_e && !out_e;
            if (out_e && q.pend) begin
                d.tx_sr = {q.tx_sr[6:0], 1'b0};
                d.pend  = 1'b0;
            end
            if (smp_e) begin
                d.rx_sr = {q.rx_sr[6:0], q.sdi_s};
                d.pend  = 1'b1;
                d.nsamp = q.nsamp + 4'h1;
                if (q.nsamp == ssp_pkg::LAST_SAMP) begin
                    ev_done = 1'b1;
                    d.pend  = 1'b0;
                    d.nsamp = 4'h0;
                end
            end
        end
        // Software clears go first so hardware sets win
        if (rd_buf) begin
            d.full = 1'b0;
        end
        if (ev_done) begin
            d.pflg[ssp_pkg::PIR_SSP] = 1'b1;
            if (!master_w && q.full) begin
                d.con[ssp_pkg::CON_OV] = 1'b1;
            end else begin
                d.sbuf = {q.rx_sr[6:0], q.sdi_s};
                d.full = 1'b1;
            end
        end
    end

    // State register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q       <= '0;
            q.dira  <= ssp_pkg::DIRA_RST;
            q.dirc  <= ssp_pkg::DIRC_RST;
        end else begin
            q <= d;
        end
    end

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // Slave overrun keeps the old byte and flags overflow
    property p_ovf_slave;
        (ev_done && !master_w && q.full) |=> (q.con[ssp_pkg::CON_OV] && $stable(q.sbuf));
    endproperty
    a_ovf_slave: assert property (p_ovf_slave) else $error("overrun not flagged");

    // Master completion never raises overflow and always loads the buffer
    property p_no_ovf_master;
        (ev_done && master_w && !q.con[ssp_pkg::CON_OV]) |=> (!q.con[ssp_pkg::CON_OV] && q.full);
    endproperty
    a_no_ovf_master: assert property (p_no_ovf_master) else $error("master overflow");

    // Disabled port drives no pin
    property p_pins_off;
        !en_w |-> (!pin_o.sck_oe && !pin_o.sdo_oe);
    endproperty
    a_pins_off: assert property (p_pins_off) else $error("pin driven while disabled");

    // Idle master clock rests at the polarity level
    property p_idle_level;
        (master_w && !q.busy)[*2] |-> (pin_o.sck_o == pol);
    endproperty
    a_idle_level: assert property (p_idle_level) else $error("wrong idle level");

    // A started master byte at any rate but the timer rate completes and the clock returns to idle
    sequence s_go;
        master_w && (mode != ssp_pkg::MD_MT2) && $rose(q.busy);
    endsequence
    sequence s_finish;
        ##[1:600] ev_done ##[0:80] !q.busy;
    endsequence
    property p_byte;
        s_go |-> (s_finish or (##[1:600] !en_w));
    endproperty
    a_byte: assert property (p_byte) else $error("byte did not complete");

    // Clock pin direction follows the role
    property p_sck_dir;
        (!master_w |-> !pin_o.sck_oe) and
        (master_w |-> (pin_o.sck_oe == !q.dirc[ssp_pkg::TRC_SCK]));
    endproperty
    a_sck_dir: assert property (p_sck_dir) else $error("clock direction wrong");

    // Data moves one place on each output edge that follows a sample
    property p_out_shift;
        (out_e && q.pend && en_w && !ss_rst) |=> (q.tx_sr[7:1] == $past(q.tx_sr[6:0]));
    endproperty
    a_out_shift: assert property (p_out_shift) else $error("output not shifted");

    // Fastest master rate holds each clock level two cycles
    property p_rate;
        (master_w && (mode == ssp_pkg::MD_M4) && q.busy && $changed(q.sck))
            |=> ($stable(q.sck) ##1 ($changed(q.sck) || !q.busy));
    endproperty
    a_rate: assert property (p_rate) else $error("master rate wrong");

    // Raised select clears the slave shifter and releases data out
    property p_ss_reset;
        ss_rst |=> ((q.nsamp == 4'h0) && !q.pend);
    endproperty
    a_ss_reset: assert property (p_ss_reset) else $error("select did not reset");

    // Completion raises the port interrupt flag
    property p_irq_flag;
        ev_done |=> q.pflg[ssp_pkg::PIR_SSP];
    endproperty
    a_irq_flag: assert property (p_irq_flag) else $error("flag not set");

    // Buffer read clears full unless a byte lands at once
    property p_bf_clear;
        (rd_buf && !ev_done) |=> !q.full;
    endproperty
    a_bf_clear: assert property (p_bf_clear) else $error("full not cleared");
endmodule

// ===== src/ssp_pkg.sv
// Constants and types of the synchronous serial port
package ssp_pkg;
    // Register indexes; byte address is index times four
    localparam logic [7:0] IDX_GCTL   = 8'h0b;
    localparam logic [7:0] IDX_PFLG   = 8'h0c;
    localparam logic [7:0] IDX_BUF    = 8'h13;
    localparam logic [7:0] IDX_CON    = 8'h14;
    localparam logic [7:0] IDX_DIRA   = 8'h85;
    localparam logic [7:0] IDX_DIRC   = 8'h87;
    localparam logic [7:0] IDX_PEN    = 8'h8c;
    localparam logic [7:0] IDX_STAT   = 8'h94;
    localparam int         IDX_LSB    = 2;
    localparam int         IDX_W      = 8;

    // Field positions
    localparam int CON_COL  = 7;
    localparam int CON_OV   = 6;
    localparam int CON_EN   = 5;
    localparam int CON_POL  = 4;
    localparam int STAT_SPH = 7;
    localparam int STAT_CKE = 6;
    localparam int STAT_FULL = 0;
    localparam int PIR_SSP  = 3;
    localparam int TRC_SCK  = 3;
    localparam int TRC_SDO  = 5;

    // Mode field codes
    localparam logic [3:0] MD_M4  = 4'h0;
    localparam logic [3:0] MD_M16 = 4'h1;
    localparam logic [3:0] MD_M64 = 4'h2;
    localparam logic [3:0] MD_MT2 = 4'h3;
    localparam logic [3:0] MD_SSS = 4'h4;

    // Half periods of the master clock in oscillator cycles
    localparam logic [5:0] HALF_4  = 6'h02;
    localparam logic [5:0] HALF_16 = 6'h08;
    localparam logic [5:0] HALF_64 = 6'h20;

    // Masks, reset values and counts
    localparam logic [7:0] PIR_USED   = 8'h4f;
    localparam logic [7:0] DIRA_MASK  = 8'h3f;
    localparam logic [7:0] DIRA_RST   = 8'h3f;
    localparam logic [7:0] DIRC_RST   = 8'hff;
    localparam logic [3:0] LAST_SAMP  = 4'h7;
    localparam logic [4:0] LAST_EDGE  = 5'h0f;
    localparam logic [1:0] RESP_OKAY  = 2'h0;
    localparam logic [1:0] RESP_ERR   = 2'h2;

    // Pins of the port
    typedef struct packed {
        logic sck;
        logic serial_in_pin;
        logic ss_n;
    } ssp_pin_in_t;

    typedef struct packed {
        logic sck_o;
        logic sck_oe;
        logic sdo_o;
        logic sdo_oe;
    } ssp_pin_out_t;

    // Whole state of the port
    typedef struct packed {
        logic [7:0] gctl;
        logic [7:0] pflg;
        logic [7:0] pen;
        logic [7:0] sbuf;
        logic [7:0] con;
        logic [7:0] dira;
        logic [7:0] dirc;
        logic [1:0] cfg;
        logic       full;
        logic [7:0] tx_sr;
        logic [7:0] rx_sr;
        logic [3:0] nsamp;
        logic [4:0] nedge;
        logic       pend;
        logic       busy;
        logic       sck;
        logic [5:0] div;
        logic       sck_m;
        logic       sck_s;
        logic       sck_p;
        logic       sdi_m;
        logic       sdi_s;
        logic       ss_m;
        logic       ss_s;
        logic       aw_ok;
        logic [7:0] aw_idx;
        logic       aw_bad;
        logic       w_ok;
        logic       w_lane;
        logic [7:0] w_dat;
        logic       bvalid;
        logic [1:0] bresp;
        logic       rvalid;
        logic [7:0] rdata;
        logic [1:0] rresp;
    } ssp_state_t;
endpackage

// ===== bench/ssps_partner.sv
// Behavioural SPI partner at the far side of the serial port
module ssps_partner (
    input  wire logic sck_o,
    input  wire logic sdo_o,
    input  wire logic cke,
    output logic      sck,
    output logic      serial_in_pin,
    output logic      ss_n
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] tx_q = 8'h00;
    logic [7:0] rx_q = 8'h00;
    int         n = 0;
    logic       lead = 1'b0;
    initial begin
        sck = 1'b0;
        serial_in_pin = 1'b0;
        ss_n = 1'b1;
    end
    // Loads the byte to send and presents its first bit
    task automatic arm(input logic [7:0] b);
        tx_q = b;
        n = 0;
        serial_in_pin = b[7];
    endtask
    // Samples on one clock edge, shifts on the other, MSB first
    task automatic step(input logic s);
        if (s ^ cke) begin
            rx_q = {rx_q[6:0], sdo_o};
            n++;
        end else if (n > 0) begin
            serial_in_pin = (n < 8) ? tx_q[7-n] : ~serial_in_pin;
        end
    endtask
    // Follows the design's clock while the design leads
    always @(sck_o) begin
        if (!lead) begin
            step(sck_o);
        end
    end
    // Leads one byte at the link rate; clock stands at idle between frames
    task automatic xfer(input logic pol, input logic [7:0] b);
        lead = 1'b1;
        sck = pol;
        arm(b);
        ss_n = 1'b0;
        #40;
        repeat (16) begin
            #32;
            sck = ~sck;
            step(sck);
        end
        #32;
        ss_n = 1'b1;
        serial_in_pin = ~serial_in_pin;
        lead = 1'b0;
    endtask
endmodule

// ===== bench/sync_serial_port_spi_tb.sv
// Self-checking testbench of the serial port with its SPI partner
module sync_serial_port_spi_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [11:0] awaddr = 12'h000;
    logic [11:0] araddr = 12'h000;
    logic [31:0] wdata = 32'h0;
    logic        awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, tmr2_tick = 1'b0;
    logic        awready, wready, arready, bvalid, rvalid, irq, p_sck, p_sdi, p_ss_n;
    logic [1:0]  bresp, rresp, resp;
    logic [31:0] rdata, rdv, rnd;
    logic [31:0] seed = 32'h47ef8dae;
    logic [1:0]  tdiv = 2'h0;
    logic [3:0]  md;
    logic        pol, cke = 1'b0;
    int          c, h, cyc = 0, err_count = 0, total_checks = 0;
    ssp_pkg::ssp_pin_in_t  pin_i;
    ssp_pkg::ssp_pin_out_t pin_o;
    localparam logic [7:0] RIDX [6] = '{ssp_pkg::IDX_PFLG, ssp_pkg::IDX_CON, ssp_pkg::IDX_DIRA,
                                        ssp_pkg::IDX_DIRC, ssp_pkg::IDX_PEN, ssp_pkg::IDX_STAT};
    localparam logic [7:0] RVAL [6] = '{8'h00, 8'h00, 8'h3f, 8'hff, 8'h00, 8'h00};

    assign pin_i = {p_sck, p_sdi, p_ss_n};
    ssp_spi_top #(.ADDR_W(12)) uut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
        .tmr2_tick(tmr2_tick), .pin_i(pin_i), .pin_o(pin_o), .irq(irq));
    ssps_partner prt (.sck_o(pin_o.sck_o), .sdo_o(pin_o.sdo_o), .cke(cke), .sck(p_sck),
                      .serial_in_pin(p_sdi), .ss_n(p_ss_n));

    // Clock, timer tick every four cycles, and run-time ceiling
    always #2 aclk = ~aclk;
    always @(posedge aclk) begin
        tdiv <= tdiv + 2'h1;
        tmr2_tick <= (tdiv == 2'h3);
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            err_count++;
            test_done();
        end
    end

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // Expected control byte and master half period in clock cycles
    function automatic logic [7:0] con_val(logic en, logic p, logic [3:0] m);
        return {2'b00, en, p, m};
    endfunction
    function automatic int half_of(logic [3:0] m);
        return (m == 4'h0) ? 2 : (m == 4'h1) ? 8 : (m == 4'h2) ? 32 : 4;
    endfunction

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Register write; address and data offered together, each released when taken
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic ta, tw, gb;
        gb = 1'b0;
        awaddr <= {2'b00, idx, 2'b00};
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!gb) begin
            @(negedge aclk);
            ta = awvalid & awready;
            tw = wvalid & wready;
            gb = bvalid;
            resp = bresp;
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
        end
    endtask
    task automatic rd(input logic [7:0] idx);
        logic ta, gr;
        gr = 1'b0;
        araddr <= {2'b00, idx, 2'b00};
        arvalid <= 1'b1;
        while (!gr) begin
            @(negedge aclk);
            ta = arvalid & arready;
            gr = rvalid;
            rdv = rdata;
            resp = rresp;
            @(posedge aclk);
            if (ta) arvalid <= 1'b0;
        end
    endtask
    task automatic rc(input string nm, input logic [7:0] idx, input logic [7:0] e);
        rd(idx);
        chk(nm, {24'h0, e}, rdv);
    endtask
    task automatic wait_irq();
        c = 0;
        do begin
            @(negedge aclk);
            c++;
        end while (irq !== 1'b1 && c < 3000);
        if (irq !== 1'b1) begin
            err_count++;
            $display("mismatch irq wait expected 1 seen %b", irq);
        end
        @(posedge aclk);
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        for (int k = 0; k < 6; k++) rc("reset value", RIDX[k], RVAL[k]);
        rd(8'h10);
        chk("unmapped rresp", {30'h0, ssp_pkg::RESP_ERR}, {30'h0, resp});
        wr(8'h10, 8'h55);
        chk("unmapped bresp", {30'h0, ssp_pkg::RESP_ERR}, {30'h0, resp});
        wr(ssp_pkg::IDX_DIRC, 8'hd7);
        wr(ssp_pkg::IDX_PEN, 8'h08);
        // Master transfers in every rate; first byte left unread
        for (int i = 0; i < 4; i++) begin
            md = i[3:0];
            cke = i[0];
            rnd = xs();
            pol = rnd[0];
            h = half_of(md);
            wr(ssp_pkg::IDX_CON, 8'h00);
            wr(ssp_pkg::IDX_STAT, {1'b0, cke, 6'h00});
            wr(ssp_pkg::IDX_CON, con_val(1'b0, pol, md));
            wr(ssp_pkg::IDX_CON, con_val(1'b1, pol, md));
            chk("sck idle", {31'h0, pol}, {31'h0, pin_o.sck_o});
            chk("sck_oe", 32'h1, {31'h0, pin_o.sck_oe});
            chk("sdo_oe", 32'h1, {31'h0, pin_o.sdo_oe});
            prt.arm(rnd[23:16]);
            wr(ssp_pkg::IDX_BUF, rnd[15:8]);
            wait_irq();
            chk("rate", 32'h1, {31'h0, (c >= 14 * h && c <= 16 * h + 6)});
            chk("sent byte", {24'h0, rnd[15:8]}, {24'h0, prt.rx_q});
            repeat (2 * h + 4) @(posedge aclk);
            chk("sck idle", {31'h0, pol}, {31'h0, pin_o.sck_o});
            rc("control", ssp_pkg::IDX_CON, con_val(1'b1, pol, md));
            if (i > 0) rc("received", ssp_pkg::IDX_BUF, rnd[23:16]);
            wr(ssp_pkg::IDX_PFLG, 8'h08);
            chk("irq", 32'h0, {31'h0, irq});
        end
        // Slave with select: overrun keeps the first byte
        cke = 1'b0;
        wr(ssp_pkg::IDX_CON, 8'h00);
        wr(ssp_pkg::IDX_STAT, 8'h00);
        wr(ssp_pkg::IDX_DIRC, 8'hdf);
        wr(ssp_pkg::IDX_CON, 8'h04);
        wr(ssp_pkg::IDX_CON, 8'h24);
        chk("sdo_oe deselected", 32'h0, {31'h0, pin_o.sdo_oe});
        chk("sck_oe slave", 32'h0, {31'h0, pin_o.sck_oe});
        rnd = xs();
        wr(ssp_pkg::IDX_BUF, rnd[7:0]);
        prt.xfer(1'b0, rnd[15:8]);
        wait_irq();
        chk("slave sent", {24'h0, rnd[7:0]}, {24'h0, prt.rx_q});
        rc("full", ssp_pkg::IDX_STAT, 8'h01);
        wr(ssp_pkg::IDX_PFLG, 8'h08);
        prt.xfer(1'b0, rnd[23:16]);
        wait_irq();
        rc("overflow", ssp_pkg::IDX_CON, 8'h64);
        rc("kept byte", ssp_pkg::IDX_BUF, rnd[15:8]);
        rc("emptied", ssp_pkg::IDX_STAT, 8'h00);
        wr(ssp_pkg::IDX_PEN, 8'h00);
        chk("masked irq", 32'h0, {31'h0, irq});
        wr(ssp_pkg::IDX_PEN, 8'h08);
        chk("irq", 32'h1, {31'h0, irq});
        wr(ssp_pkg::IDX_PFLG, 8'h08);
        chk("cleared irq", 32'h0, {31'h0, irq});
        wr(ssp_pkg::IDX_CON, 8'h24);
        rc("overflow cleared", ssp_pkg::IDX_CON, 8'h24);
        // Other receive mode flags overrun as well
        wr(ssp_pkg::IDX_CON, 8'h00);
        wr(ssp_pkg::IDX_CON, 8'h26);
        prt.xfer(1'b0, rnd[31:24]);
        wait_irq();
        wr(ssp_pkg::IDX_PFLG, 8'h08);
        prt.xfer(1'b0, rnd[7:0]);
        wait_irq();
        rc("second mode overflow", ssp_pkg::IDX_CON, 8'h66);
        wr(ssp_pkg::IDX_CON, 8'h00);
        chk("sdo_oe off", 32'h0, {31'h0, pin_o.sdo_oe});
        chk("sck_oe off", 32'h0, {31'h0, pin_o.sck_oe});
        test_done();
    end
endmodule
